// File: hdl/xper_pkg.sv
// Constants, field layouts and types shared by the extension peripheral select block.
// Assumes a single 100 MHz clock and a synchronous active-low reset around it.
// Summary of operation
// - Group level breaks ties, three highest, zero lowest.
// - Priority level ranks requests, Fh highest, zero lowest.
// - Enable bit gates each source into arbitration.
// - Request flag bit 7 shows pending, software writable.
// - Port three control uses generic layout, resets zero.
// - First controller off: window external only if both off.
// - Second controller off: window external only if both off.
// - Small RAM enable picks internal or external window.
// - Large RAM enable picks internal or external window.
// - Clock off: external only when both controllers off.
// - Both controllers off: shared window goes external.
// - Selection resets to 05h.
// - Global enable set locks selection against writes.
// - Emulation mode reads every selection bit set.
// - Oscillator stop depends on clock enable and control.
// - Port pins released when their controller is off.

package xper_pkg;

  // Number of interrupt sources; source zero is the port three control.
  localparam int NSRC  = 4;
  localparam int IDX_W = 2;
  localparam int AW    = 18;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] XSEL_IDX = 16'hF024;
  localparam logic [15:0] SCFG_IDX = 16'hF202;
  localparam logic [15:0] STAT_IDX = 16'hF200;
  localparam logic [15:0] MASK_IDX = 16'hF201;
  localparam logic [NSRC-1:0][15:0] IC_IDX = {16'hF1A4, 16'hF1A2, 16'hF1A0, 16'hF19E};

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sticky event bits of the status register.
  localparam int STAT_W   = 3;
  localparam int EV_BLOCK = 0;
  localparam int EV_GRANT = 1;
  localparam int EV_DEAD  = 2;

  // Positions of port four pins four to seven in the release vector.
  localparam int P44 = 0;
  localparam int P45 = 1;
  localparam int P46 = 2;
  localparam int P47 = 3;

  // Address windows of the extension peripherals and RAMs.
  localparam logic [23:0] LRAM_LO = 24'h00C000;
  localparam logic [23:0] LRAM_HI = 24'h00DFFF;
  localparam logic [23:0] SRAM_LO = 24'h00E000;
  localparam logic [23:0] SRAM_HI = 24'h00E7FF;
  localparam logic [23:0] RTC_LO  = 24'h00EC00;
  localparam logic [23:0] RTC_HI  = 24'h00ECFF;
  localparam logic [23:0] BUSB_LO = 24'h00EE00;
  localparam logic [23:0] BUSB_HI = 24'h00EEFF;
  localparam logic [23:0] BUSA_LO = 24'h00EF00;
  localparam logic [23:0] BUSA_HI = 24'h00EFFF;

  // Bus channel states, Gray coded.
  typedef enum logic [1:0] {W_IDLE = 2'h0, W_RESP = 2'h1} wr_state_t;
  typedef enum logic {R_IDLE = 1'h0, R_DATA = 1'h1} rd_state_t;

  // Selection register layout, bit zero at the bottom.
  typedef struct packed {
    logic rtc;
    logic lram;
    logic sram;
    logic bus_b;
    logic bus_a;
  } xsel_t;

  localparam xsel_t XSEL_RESET = 5'h05;

  // Generic interrupt control layout, bit seven at the top.
  typedef struct packed {
    logic       req;
    logic       en;
    logic [3:0] prio;
    logic [1:0] grp;
  } irq_ctrl_t;

  localparam irq_ctrl_t IC_RESET = 8'h00;

  // Where one access is steered.
  typedef struct packed {
    logic ext;
    logic bus_a;
    logic bus_b;
    logic rtc;
    logic sram;
    logic lram;
    logic dead;
  } route_t;

endpackage : xper_pkg

// File: hdl/xirq_arbiter.sv
// Picks the winning interrupt request among all sources.
// Assumes the control words are registered in the caller.
`timescale 1ns/1ps
`default_nettype none

module xirq_arbiter (
  input  wire logic                                      aclk,
  input  wire logic                                      aresetn,
  input  wire xper_pkg::irq_ctrl_t [xper_pkg::NSRC-1:0]  ctrl,
  output logic                                           valid,
  output logic [xper_pkg::IDX_W-1:0]                     idx,
  output logic [3:0]                                     prio
);

  logic [5:0] best;        // Rank of the current winner, level over group.
  logic       beat_prio;   // Some eligible source has a higher level.
  logic       beat_grp;    // Some eligible source ties level, higher group.

  // Scan sources; a strict compare keeps the lowest index on a full tie.
  always_comb begin
    valid = 1'b0;
    idx   = '0;
    best  = 6'h00;
    for (int i = 0; i < xper_pkg::NSRC; i++) begin
      if (ctrl[i].req && ctrl[i].en &&
          (!valid || {ctrl[i].prio, ctrl[i].grp} > best)) begin
        valid = 1'b1;
        idx   = xper_pkg::IDX_W'(i);
        best  = {ctrl[i].prio, ctrl[i].grp};
      end
    end
    prio = best[5:2];
  end

  // Helper scan that looks for any source that should have beaten the winner.
  always_comb begin
    beat_prio = 1'b0;
    beat_grp  = 1'b0;
    for (int i = 0; i < xper_pkg::NSRC; i++) begin
      if (ctrl[i].req && ctrl[i].en && ctrl[i].prio > prio) begin
        beat_prio = 1'b1;
      end
      if (ctrl[i].req && ctrl[i].en && ctrl[i].prio == prio &&
          ctrl[i].grp > best[1:0]) begin
        beat_grp = 1'b1;
      end
    end
  end

  chk_rank_order: assert property (@(posedge aclk) disable iff (!aresetn)
    valid |-> !beat_prio) else $error("higher level request lost");
  chk_group_tie: assert property (@(posedge aclk) disable iff (!aresetn)
    valid |-> !beat_grp) else $error("group tie broken wrongly");
  chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    valid |-> ctrl[idx].en && ctrl[idx].req) else $error("disabled source granted");

endmodule : xirq_arbiter

`default_nettype wire

// File: hdl/xperipheral_select_and_irq_ctrl.sv
// Extension peripheral selection, address steering and interrupt control registers.
// Assumes an AXI4-Lite master on aclk and synchronous, registered access requests.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module xperipheral_select_and_irq_ctrl (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // AXI4-Lite slave.
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [xper_pkg::AW-1:0]         awaddr,
  input  wire logic                            wvalid,
  output logic                                 wready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  output logic                                 bvalid,
  input  wire logic                            bready,
  output logic [1:0]                           bresp,
  input  wire logic                            arvalid,
  output logic                                 arready,
  input  wire logic [xper_pkg::AW-1:0]         araddr,
  output logic                                 rvalid,
  input  wire logic                            rready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  // System side.
  input  wire logic                            emu_mode,
  input  wire logic                            power_down_entry,
  input  wire logic                            rtc_osc_off_select,
  input  wire logic                            xacc_valid,
  input  wire logic [23:0]                     xacc_addr,
  input  wire logic [xper_pkg::NSRC-1:0]       irq_event,
  input  wire logic                            irq_ack,
  output xper_pkg::xsel_t                      xsel_eff,
  output logic                                 global_xper_enable,
  output logic                                 route_valid,
  output xper_pkg::route_t                     route,
  output logic [3:0]                           gpio_release,
  output logic                                 rtc_osc_stop,
  output logic                                 grant_valid,
  output logic [xper_pkg::IDX_W-1:0]           grant_idx,
  output logic [3:0]                           grant_prio,
  output logic                                 irq_out
);

  // Whole state of the block.
  typedef struct packed {
    xper_pkg::wr_state_t                     wst;
    logic                                    aw_got;
    logic                                    w_got;
    logic [15:0]                             awidx;
    logic [15:0]                             wdat;
    logic [1:0]                              wstb;
    logic [1:0]                              bresp;
    xper_pkg::rd_state_t                     rst;
    logic [15:0]                             rdat;
    logic [1:0]                              rresp;
    xper_pkg::xsel_t                         xsel;
    xper_pkg::xsel_t                         eff;
    logic                                    scfg;
    xper_pkg::irq_ctrl_t [xper_pkg::NSRC-1:0] ic;
    logic [xper_pkg::STAT_W-1:0]             stat;
    logic [xper_pkg::STAT_W-1:0]             mask;
    logic                                    route_v;
    xper_pkg::route_t                        route;
    logic [3:0]                              gpio;
    logic                                    osc_stop;
    logic                                    gnt_v;
    logic [xper_pkg::IDX_W-1:0]              gnt_idx;
    logic [3:0]                              gnt_prio;
  } st_t;

  st_t q;                                      // Registered state.
  st_t d;                                      // Next state.
  logic [xper_pkg::STAT_W-1:0] ev;             // Events raised this cycle.
  logic [15:0]                 ridx;           // Read register index.
  logic                        whit;           // Write landed on a register.
  xper_pkg::route_t            r;              // Steering of the current access.
  logic                        arb_v;          // Arbiter has a winner.
  logic [xper_pkg::IDX_W-1:0]  arb_idx;        // Winning source.
  logic [3:0]                  arb_prio;       // Winning level.
  logic [xper_pkg::NSRC-1:0]   reqv;           // Request flags, for checking.

  // Window hits of the incoming access.
  logic in_a;
  logic in_b;
  logic in_rtc;
  logic in_s;
  logic in_l;
  assign in_a   = xacc_addr >= xper_pkg::BUSA_LO && xacc_addr <= xper_pkg::BUSA_HI;
  assign in_b   = xacc_addr >= xper_pkg::BUSB_LO && xacc_addr <= xper_pkg::BUSB_HI;
  assign in_rtc = xacc_addr >= xper_pkg::RTC_LO && xacc_addr <= xper_pkg::RTC_HI;
  assign in_s   = xacc_addr >= xper_pkg::SRAM_LO && xacc_addr <= xper_pkg::SRAM_HI;
  assign in_l   = xacc_addr >= xper_pkg::LRAM_LO && xacc_addr <= xper_pkg::LRAM_HI;

  // The arbiter looks at registered control words only.
  xirq_arbiter u_arb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctrl    (q.ic),
    .valid   (arb_v),
    .idx     (arb_idx),
    .prio    (arb_prio)
  );

  // Next-state logic: bus writes first, hardware events last so a set wins a clear.
  always_comb begin
    d    = q;
    ev   = '0;
    whit = 1'b0;
    r    = '0;
    ridx = araddr[xper_pkg::AW-1:2];

    // Address and data are taken in either order and held until both are here.
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.awidx  = awaddr[xper_pkg::AW-1:2];
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.wdat  = wdata[15:0];
      d.wstb  = wstrb[1:0];
    end

    // Write channel.
    case (q.wst)
      xper_pkg::W_IDLE: begin
        if (q.aw_got && q.w_got) begin
          d.wst = xper_pkg::W_RESP;
          if (q.awidx == xper_pkg::XSEL_IDX) begin
            whit = 1'b1;
            if (q.wstb[0] && q.scfg) begin
              ev[xper_pkg::EV_BLOCK] = 1'b1;
            end else if (q.wstb[0]) begin
              d.xsel = xper_pkg::xsel_t'(q.wdat[4:0]);
            end
          end
          if (q.awidx == xper_pkg::SCFG_IDX) begin
            whit = 1'b1;
            if (q.wstb[0]) begin
              d.scfg = q.wdat[0];
            end
          end
          if (q.awidx == xper_pkg::STAT_IDX) begin
            whit = 1'b1;
            if (q.wstb[0]) begin
              d.stat = q.stat & ~q.wdat[xper_pkg::STAT_W-1:0];
            end
          end
          if (q.awidx == xper_pkg::MASK_IDX) begin
            whit = 1'b1;
            if (q.wstb[0]) begin
              d.mask = q.wdat[xper_pkg::STAT_W-1:0];
            end
          end
          // The upper byte of every control word is unused and dropped.
          for (int i = 0; i < xper_pkg::NSRC; i++) begin
            if (q.awidx == xper_pkg::IC_IDX[i]) begin
              whit = 1'b1;
              if (q.wstb[0]) begin
                d.ic[i] = xper_pkg::irq_ctrl_t'(q.wdat[7:0]);
              end
            end
          end
          d.bresp = whit ? xper_pkg::RESP_OKAY : xper_pkg::RESP_SLVERR;
        end
      end
      xper_pkg::W_RESP: begin
        if (bready) begin
          d.wst    = xper_pkg::W_IDLE;
          d.aw_got = 1'b0;
          d.w_got  = 1'b0;
        end
      end
      default: begin
        d.wst = xper_pkg::W_IDLE;
      end
    endcase

    // Read channel; data is sampled when the address is taken.
    case (q.rst)
      xper_pkg::R_IDLE: begin
        if (arvalid) begin
          d.rst   = xper_pkg::R_DATA;
          d.rdat  = 16'h0000;
          d.rresp = xper_pkg::RESP_OKAY;
          if (ridx == xper_pkg::XSEL_IDX) begin
            d.rdat = 16'(q.eff);
          end else if (ridx == xper_pkg::SCFG_IDX) begin
            d.rdat = 16'(q.scfg);
          end else if (ridx == xper_pkg::STAT_IDX) begin
            d.rdat = 16'(q.stat);
          end else if (ridx == xper_pkg::MASK_IDX) begin
            d.rdat = 16'(q.mask);
          end else begin
            d.rresp = xper_pkg::RESP_SLVERR;
          end
          for (int i = 0; i < xper_pkg::NSRC; i++) begin
            if (ridx == xper_pkg::IC_IDX[i]) begin
              d.rdat  = 16'(q.ic[i]);
              d.rresp = xper_pkg::RESP_OKAY;
            end
          end
        end
      end
      xper_pkg::R_DATA: begin
        if (rready) begin
          d.rst = xper_pkg::R_IDLE;
        end
      end
      default: begin
        d.rst = xper_pkg::R_IDLE;
      end
    endcase

    // Request flags: acknowledge clears the granted one, a new event sets it.
    for (int i = 0; i < xper_pkg::NSRC; i++) begin
      if (irq_ack && q.gnt_v && q.gnt_idx == xper_pkg::IDX_W'(i)) begin
        d.ic[i].req = 1'b0;
      end
      if (irq_event[i]) begin
        d.ic[i].req = 1'b1;
      end
    end

    // Steering; a blocked window is answered by nobody, so no peripheral sees it.
    if (in_a) begin
      r.bus_a = q.eff.bus_a;
      r.ext   = !q.eff.bus_a && !q.eff.bus_b;
      r.dead  = !q.eff.bus_a && q.eff.bus_b;
    end else if (in_b) begin
      r.bus_b = q.eff.bus_b;
      r.ext   = !q.eff.bus_b && !q.eff.bus_a;
      r.dead  = !q.eff.bus_b && q.eff.bus_a;
    end else if (in_rtc) begin
      r.rtc  = q.eff.rtc;
      r.ext  = !q.eff.rtc && !q.eff.bus_a && !q.eff.bus_b;
      r.dead = !q.eff.rtc && (q.eff.bus_a || q.eff.bus_b);
    end else if (in_s) begin
      r.sram = q.eff.sram;
      r.ext  = !q.eff.sram;
    end else if (in_l) begin
      r.lram = q.eff.lram;
      r.ext  = !q.eff.lram;
    end
    d.route_v = xacc_valid;
    d.route   = xacc_valid ? r : '0;
    ev[xper_pkg::EV_DEAD] = xacc_valid && r.dead;

    // Grant pipeline stage and its arrival event.
    d.gnt_v    = arb_v;
    d.gnt_idx  = arb_idx;
    d.gnt_prio = arb_prio;
    ev[xper_pkg::EV_GRANT] = arb_v && !q.gnt_v;

    // Sticky status; a new event beats a clear in the same cycle.
    d.stat = d.stat | ev;

    // Emulation forces every selection bit; the stored value is kept underneath.
    d.eff = emu_mode ? xper_pkg::xsel_t'(5'h1F) : d.xsel;

    // Pins follow the controller that owns them.
    d.gpio[xper_pkg::P44] = !d.eff.bus_b;
    d.gpio[xper_pkg::P47] = !d.eff.bus_b;
    d.gpio[xper_pkg::P45] = !d.eff.bus_a;
    d.gpio[xper_pkg::P46] = !d.eff.bus_a;

    // At power-down entry the oscillator always stops with the clock off, else the control bit decides.
    d.osc_stop = power_down_entry && (!d.eff.rtc || rtc_osc_off_select);
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.xsel <= xper_pkg::XSEL_RESET;
      q.eff  <= xper_pkg::XSEL_RESET;
      q.ic   <= {xper_pkg::NSRC{xper_pkg::IC_RESET}};
      q.gpio <= 4'h9;
    end else begin
      q <= d;
    end
  end

  // Outputs.
  assign awready            = q.wst == xper_pkg::W_IDLE && !q.aw_got;
  assign wready             = q.wst == xper_pkg::W_IDLE && !q.w_got;
  assign bvalid             = q.wst == xper_pkg::W_RESP;
  assign bresp              = q.bresp;
  assign arready            = q.rst == xper_pkg::R_IDLE;
  assign rvalid             = q.rst == xper_pkg::R_DATA;
  assign rdata              = {16'h0000, q.rdat};
  assign rresp              = q.rresp;
  assign xsel_eff           = q.eff;
  assign global_xper_enable = q.scfg;
  assign route_valid        = q.route_v;
  assign route              = q.route;
  assign gpio_release       = q.gpio;
  assign rtc_osc_stop       = q.osc_stop;
  assign grant_valid        = q.gnt_v;
  assign grant_idx          = q.gnt_idx;
  assign grant_prio         = q.gnt_prio;
  assign irq_out            = |(q.stat & q.mask);

  // Checks.
  always_comb begin
    for (int i = 0; i < xper_pkg::NSRC; i++) begin
      reqv[i] = q.ic[i].req;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sel_write;
    q.wst == xper_pkg::W_IDLE && q.aw_got && q.w_got && q.awidx == xper_pkg::XSEL_IDX;
  endsequence

  chk_sel_reset: assert property (disable iff (1'b0)
    !aresetn |=> q.xsel == xper_pkg::XSEL_RESET && q.ic[0] == '0) else $error("bad reset");
  chk_lock_hold: assert property (s_sel_write ##0 q.scfg && q.wstb[0]
    |=> $stable(q.xsel) && q.stat[xper_pkg::EV_BLOCK]) else $error("locked select changed");
  chk_emu_all: assert property (emu_mode |=> &q.eff)
    else $error("emulation not forcing select");
  chk_bus_a_path: assert property (xacc_valid && in_a && !q.eff.bus_a
    |=> !route.bus_a && route.ext == !$past(q.eff.bus_b)) else $error("bad first window");
  chk_bus_b_path: assert property (xacc_valid && in_b && !q.eff.bus_b
    |=> !route.bus_b && route.ext == !$past(q.eff.bus_a)) else $error("bad second window");
  chk_shared_ext: assert property (xacc_valid && (in_a || in_b)
    && !q.eff.bus_a && !q.eff.bus_b |=> route.ext) else $error("shared window not external");
  chk_rtc_path: assert property (xacc_valid && in_rtc && !q.eff.rtc
    |=> !route.rtc && route.dead == !route.ext) else $error("bad clock window");
  chk_dead_quiet: assert property (route_valid && route.dead
    |-> !(route.ext || route.bus_a || route.bus_b || route.rtc)) else $error("dead access leaked");
  chk_small_ram: assert property (xacc_valid && in_s
    |=> route.sram == $past(q.eff.sram) && route.ext == !route.sram) else $error("bad small RAM");
  chk_large_ram: assert property (xacc_valid && in_l
    |=> route.lram == $past(q.eff.lram) && route.ext == !route.lram) else $error("bad large RAM");
  chk_req_flag: assert property (irq_event != '0
    |=> (reqv & $past(irq_event)) == $past(irq_event)) else $error("request event lost");
  chk_pin_free: assert property (gpio_release[xper_pkg::P47] == !q.eff.bus_b
    && gpio_release[xper_pkg::P45] == !q.eff.bus_a) else $error("pin release mismatch");
  chk_osc_stop: assert property (power_down_entry && !emu_mode && !q.xsel.rtc
    && !$rose(q.scfg) && q.wst != xper_pkg::W_IDLE |=> rtc_osc_stop) else $error("osc not stopped");

endmodule : xperipheral_select_and_irq_ctrl

`default_nettype wire

// File: testbench/xperipheral_select_and_irq_ctrl_test.sv
// Self-checking bench for the extension peripheral select and interrupt control block.
// Assumes the package and design files are compiled first; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module xperipheral_select_and_irq_ctrl_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq_ack;
  logic        emu_mode, power_down_entry, rtc_osc_off_select, xacc_valid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, irq_event, gpio_release, grant_prio;
  logic [23:0] xacc_addr;
  logic        awready, wready, bvalid, arready, rvalid, global_xper_enable;
  logic        route_valid, rtc_osc_stop, grant_valid, irq_out;
  logic [1:0]  bresp, rresp, grant_idx, rsp;
  xper_pkg::xsel_t  xsel_eff;
  xper_pkg::route_t route;
  int          errors, checks_done;
  // One steering case: select value, access address, expected route.
  typedef struct packed {logic [7:0] sel; logic [23:0] adr; logic [6:0] rt;} row_t;
  row_t rows [10] = '{
    '{8'h05, 24'h00E000, 7'h04}, '{8'h05, 24'h00C000, 7'h40},
    '{8'h05, 24'h00EE00, 7'h01}, '{8'h08, 24'h00DFFF, 7'h02},
    '{8'h10, 24'h00EC00, 7'h08}, '{8'h01, 24'h00EC00, 7'h01},
    '{8'h03, 24'h00EF00, 7'h20}, '{8'h02, 24'h00EEFF, 7'h10},
    '{8'h00, 24'h00EF00, 7'h40}, '{8'h00, 24'h00E7FF, 7'h40}};

  xperipheral_select_and_irq_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .emu_mode(emu_mode), .power_down_entry(power_down_entry),
    .rtc_osc_off_select(rtc_osc_off_select), .xacc_valid(xacc_valid), .xacc_addr(xacc_addr),
    .irq_event(irq_event), .irq_ack(irq_ack), .xsel_eff(xsel_eff),
    .global_xper_enable(global_xper_enable), .route_valid(route_valid), .route(route),
    .gpio_release(gpio_release), .rtc_osc_stop(rtc_osc_stop), .grant_valid(grant_valid),
    .grant_idx(grant_idx), .grant_prio(grant_prio), .irq_out(irq_out));

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Counts one comparison; case inequality so an unknown never passes.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask : chk

  // Write one word; address and data stay up until each is taken, bready until bvalid.
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] r);
    bit a, w;
    a = 0;
    w = 0;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    awaddr <= {idx, 2'h0}; wdata <= {16'h0000, d}; wstrb <= 4'hF;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !a) begin a = 1; awvalid <= 1'b0; end
      if (wready === 1'b1 && !w) begin w = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read one word; rready is held until rvalid is sampled high.
  task automatic rdw(input logic [15:0] idx, output logic [31:0] d);
    arvalid <= 1'b1; araddr <= {idx, 2'h0}; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk("rresp", 32'(xper_pkg::RESP_OKAY), 32'(rresp));
    rready <= 1'b0;
  endtask : rdw

  // Steer one access and look at the one-cycle route pulse that follows it.
  task automatic steer(input logic [23:0] a, input logic [6:0] e);
    xacc_valid <= 1'b1; xacc_addr <= a;
    @(posedge aclk);
    xacc_valid <= 1'b0;
    @(posedge aclk);
    chk("route_valid", 32'h1, 32'(route_valid));
    chk("route", 32'(e), 32'(route));
  endtask : steer

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_ack} = '0;
    {emu_mode, power_down_entry, rtc_osc_off_select, xacc_valid} = '0;
    {awaddr, araddr, wdata, wstrb, irq_event, xacc_addr} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values of selection, control word and released pins.
    chk("gpio_release", 32'h9, 32'(gpio_release));
    rdw(xper_pkg::XSEL_IDX, rd); chk("select", 32'h05, rd);
    rdw(xper_pkg::IC_IDX[0], rd); chk("port3 ctrl", 32'h0, rd);
    $display("reset test done");
    // Table of selections against steered addresses and released pins.
    foreach (rows[i]) begin
      wr(xper_pkg::XSEL_IDX, {8'h00, rows[i].sel}, rsp);
      steer(rows[i].adr, rows[i].rt);
      chk("gpio_release", 32'({~rows[i].sel[1], {2{~rows[i].sel[0]}}, ~rows[i].sel[1]}),
          32'(gpio_release));
    end
    $display("steering table done");
    // Oscillator stop at power-down entry, clock off and then on.
    power_down_entry <= 1'b1;
    wr(xper_pkg::XSEL_IDX, 16'h0005, rsp); repeat (2) @(posedge aclk);
    chk("osc_stop off", 32'h1, 32'(rtc_osc_stop));
    wr(xper_pkg::XSEL_IDX, 16'h0015, rsp); repeat (2) @(posedge aclk);
    chk("osc_stop on", 32'h0, 32'(rtc_osc_stop));
    rtc_osc_off_select <= 1'b1; repeat (3) @(posedge aclk);
    chk("osc_stop sel", 32'h1, 32'(rtc_osc_stop));
    $display("oscillator test done");
    // Arbitration: equal priority decided by group, disabled source left out.
    wr(xper_pkg::IC_IDX[0], 16'h0050, rsp); wr(xper_pkg::IC_IDX[1], 16'h0054, rsp);
    wr(xper_pkg::IC_IDX[2], 16'h0057, rsp); wr(xper_pkg::IC_IDX[3], 16'h003F, rsp);
    wr(xper_pkg::MASK_IDX, 16'h0002, rsp);
    irq_event <= 4'hF; @(posedge aclk); irq_event <= 4'h0; repeat (4) @(posedge aclk);
    chk("grant_idx", 32'h2, 32'(grant_idx));
    chk("grant_prio", 32'h5, 32'(grant_prio));
    chk("grant_valid", 32'h1, 32'(grant_valid));
    chk("irq_out", 32'h1, 32'(irq_out));
    rdw(xper_pkg::IC_IDX[3], rd); chk("src3 ctrl", 32'hBF, rd);
    irq_ack <= 1'b1; @(posedge aclk); irq_ack <= 1'b0; repeat (3) @(posedge aclk);
    chk("grant_idx", 32'h1, 32'(grant_idx));
    rdw(xper_pkg::IC_IDX[2], rd); chk("src2 ctrl", 32'h57, rd);
    wr(xper_pkg::STAT_IDX, 16'h0002, rsp); @(posedge aclk);
    chk("irq_out", 32'h0, 32'(irq_out));
    $display("interrupt test done");
    // Lock after global enable, emulation override, unmapped address.
    wr(xper_pkg::SCFG_IDX, 16'h0001, rsp); chk("global", 32'h1, 32'(global_xper_enable));
    wr(xper_pkg::XSEL_IDX, 16'h0002, rsp); chk("bresp", 32'(xper_pkg::RESP_OKAY), 32'(rsp));
    rdw(xper_pkg::XSEL_IDX, rd); chk("locked select", 32'h15, rd);
    rdw(xper_pkg::STAT_IDX, rd); chk("blocked bit", 32'h1, rd & 32'h1);
    emu_mode <= 1'b1; repeat (2) @(posedge aclk);
    rdw(xper_pkg::XSEL_IDX, rd); chk("emu select", 32'h1F, rd);
    chk("xsel_eff", 32'h1F, 32'(xsel_eff));
    wr(16'h0001, 16'h00FF, rsp); chk("unmapped", 32'(xper_pkg::RESP_SLVERR), 32'(rsp));
    $display("lock and emulation test done");
    // A reset in mid-run must restore the select default and drop the lock.
    aresetn <= 1'b0; emu_mode <= 1'b0; repeat (2) @(posedge aclk);
    aresetn <= 1'b1; @(posedge aclk);
    chk("gpio again", 32'h9, 32'(gpio_release));
    rdw(xper_pkg::XSEL_IDX, rd); chk("select again", 32'h05, rd);
    chk("global again", 32'h0, 32'(global_xper_enable));
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : xperipheral_select_and_irq_ctrl_test
`default_nettype wire
